// *** design/fsrb_pkg.sv ***
/*
 * Constants for the fault and status register bank: register offsets,
 * bit positions, serial word layout and reset values.
 * Assumes the serial framing logic hands over whole 16-bit input words
 * and the fault detectors deliver levels synchronous to SYS_CLK.
 */
// Behaviour
// - Summary bit 7 shows motor stall.
// - Summary bit 6 shows any step-down fault.
// - Summary bit 5 shows any serial error.
// - Summary bit 4 shows any switch overcurrent.
// - Summary bit 3 low after supply reset.
// - Summary bit 2 shows supply overvoltage.
// - Summary bit 1 shows thermal warning or shutdown.
// - Summary bit 0 is global fault.
// - Offset 1 bit 7 shows thermal warning.
// - Offset 1 bit 6 shows thermal shutdown.
// - Offset 1 bits 5..0 per-switch overcurrent.
// - Offset 2 bit 6 shows memory error.
// - Offset 2 bit 5 step-down overcurrent.
// - Offset 2 bit 4 step-down undervoltage.
// - Offset 2 bit 3 charge pump undervoltage.
// - Offset 2 bit 2 latches parity error.
// - Offset 2 bit 1 latches framing error.
// - Offset 2 bit 0 latches address error.
// - Input word must hold even ones.
// - Short frame latches framing error until cleared.
// - Address above 0xC latches address error.
`default_nettype none

package fsrb_pkg;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_SUMMARY = 6'h00;
    localparam logic [5:0] OFS_THERMAL_SWITCH = 6'h01;
    localparam logic [5:0] OFS_SUPPLY_LINK = 6'h02;
    localparam logic [5:0] OFS_LAST_VALID = 6'h0C;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ------------------------------------------------------------
    // Summary register bit positions
    // ------------------------------------------------------------
    localparam int SUM_STALL = 7;
    localparam int SUM_STEPDOWN = 6;
    localparam int SUM_SERIAL = 5;
    localparam int SUM_OVERCURRENT = 4;
    localparam int SUM_SUPPLY_RESET_ABSENT = 3;
    localparam int SUM_OVERVOLT = 2;
    localparam int SUM_THERMAL = 1;
    localparam int SUM_FAULT = 0;

    // ------------------------------------------------------------
    // Thermal and switch register bit positions
    // ------------------------------------------------------------
    localparam int TS_WARNING = 7;
    localparam int TS_SHUTDOWN = 6;
    localparam int TS_SWITCH_HI = 5;
    localparam int SWITCH_COUNT = 6;

    // ------------------------------------------------------------
    // Supply and link register bit positions
    // ------------------------------------------------------------
    localparam int SL_RESERVED = 7;
    localparam int SL_MEMORY = 6;
    localparam int SL_STEP_OC = 5;
    localparam int SL_STEP_UV = 4;
    localparam int SL_PUMP_UV = 3;
    localparam int SL_PARITY = 2;
    localparam int SL_FRAMING = 1;
    localparam int SL_ADDRESS = 0;

    // ------------------------------------------------------------
    // Serial input word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int WORD_RW = 15;
    localparam int WORD_ADDR_HI = 14;
    localparam int WORD_ADDR_LO = 9;

endpackage

`default_nettype wire

// *** design/fsrb_top.sv ***
/*
 * Read-only fault and status register bank with serial error capture.
 * Assumes the serial framing logic presents each complete input word
 * with a one-cycle strobe, flags short frames with a pulse, and sends
 * the reply status and data bytes out as its next word.
 */
`default_nettype none

module fsrb_top
    import fsrb_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Fault detector levels
    input wire logic STALL_DETECT,
    input wire logic SUPPLY_OVERVOLT,
    input wire logic SUPPLY_RESET_SEEN,
    input wire logic THERMAL_WARNING,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic [SWITCH_COUNT-1:0] SWITCH_OVERCURRENT,
    input wire logic MEMORY_ERROR,
    input wire logic STEPDOWN_OVERCURRENT,
    input wire logic STEPDOWN_UNDERVOLT,
    input wire logic CHARGE_PUMP_UNDERVOLT,
    // Serial word hand-over
    input wire logic WORD_VALID,
    input wire logic [WORD_W-1:0] SERIAL_WORD,
    input wire logic FRAME_SHORT,
    // Fault clearing
    input wire logic CLEAR_FAULTS,
    input wire logic SLEEP_RESET_PULSE,
    // Reply to the controller
    output logic REPLY_VALID,
    output logic [7:0] REPLY_STATUS,
    output logic [7:0] REPLY_DATA,
    output logic REPLY_IN_RANGE,
    // Register contents
    output logic [7:0] FAULT_SUMMARY_STATUS,
    output logic [7:0] THERMAL_SWITCH_CURRENT_STATUS,
    output logic [7:0] SUPPLY_LINK_ERROR_STATUS
);

    // ------------------------------------------------------------
    // Serial word decode
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] word_addr;
    logic parity_bad;
    logic addr_bad;
    logic clear_req;

    assign word_addr = SERIAL_WORD[WORD_ADDR_HI:WORD_ADDR_LO];
    assign parity_bad = ^SERIAL_WORD;
    assign addr_bad = word_addr > OFS_LAST_VALID;
    assign clear_req = CLEAR_FAULTS | SLEEP_RESET_PULSE;

    // ------------------------------------------------------------
    // Latched serial errors
    // ------------------------------------------------------------
    // Set wins over clear so an error in the clearing cycle survives
    logic parity_err;
    logic framing_err;
    logic address_err;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            parity_err <= 1'b0;
        end else if (WORD_VALID && parity_bad) begin
            parity_err <= 1'b1;
        end else if (clear_req) begin
            parity_err <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            framing_err <= 1'b0;
        end else if (FRAME_SHORT) begin
            framing_err <= 1'b1;
        end else if (clear_req) begin
            framing_err <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            address_err <= 1'b0;
        end else if (WORD_VALID && addr_bad) begin
            address_err <= 1'b1;
        end else if (clear_req) begin
            address_err <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Detail register images
    // ------------------------------------------------------------
    logic [7:0] next_thermal_switch;
    logic [7:0] next_supply_link;
    logic [7:0] next_summary;

    always_comb begin
        next_thermal_switch = STATUS_RESET;
        next_thermal_switch[TS_WARNING] = THERMAL_WARNING;
        next_thermal_switch[TS_SHUTDOWN] = THERMAL_SHUTDOWN;
        // Bit 5 is phase C high side down to bit 0, phase A low side
        next_thermal_switch[TS_SWITCH_HI:0] = SWITCH_OVERCURRENT;
    end

    always_comb begin
        next_supply_link = STATUS_RESET;
        next_supply_link[SL_RESERVED] = 1'b0;
        next_supply_link[SL_MEMORY] = MEMORY_ERROR;
        next_supply_link[SL_STEP_OC] = STEPDOWN_OVERCURRENT;
        next_supply_link[SL_STEP_UV] = STEPDOWN_UNDERVOLT;
        next_supply_link[SL_PUMP_UV] = CHARGE_PUMP_UNDERVOLT;
        next_supply_link[SL_PARITY] = parity_err;
        next_supply_link[SL_FRAMING] = framing_err;
        next_supply_link[SL_ADDRESS] = address_err;
    end

    // ------------------------------------------------------------
    // Summary derived from the detail images plus the stall, overvoltage and reset-seen inputs
    // ------------------------------------------------------------
    // Reset-seen is a notice, not a fault, so it stays out of bit 0
    always_comb begin
        next_summary = STATUS_RESET;
        next_summary[SUM_STALL] = STALL_DETECT;
        next_summary[SUM_STEPDOWN] = next_supply_link[SL_STEP_OC]
            | next_supply_link[SL_STEP_UV];
        next_summary[SUM_SERIAL] = next_supply_link[SL_PARITY]
            | next_supply_link[SL_FRAMING]
            | next_supply_link[SL_ADDRESS];
        next_summary[SUM_OVERCURRENT] =
            |next_thermal_switch[TS_SWITCH_HI:0];
        next_summary[SUM_SUPPLY_RESET_ABSENT] = ~SUPPLY_RESET_SEEN;
        next_summary[SUM_OVERVOLT] = SUPPLY_OVERVOLT;
        next_summary[SUM_THERMAL] = next_thermal_switch[TS_WARNING]
            | next_thermal_switch[TS_SHUTDOWN];
        next_summary[SUM_FAULT] = STALL_DETECT | SUPPLY_OVERVOLT
            | (|next_thermal_switch)
            | (|next_supply_link);
    end

    // ------------------------------------------------------------
    // Status registers, read-only from the serial side
    // ------------------------------------------------------------
    // Write data never reaches these flops: only detectors and the serial error latches steer them
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            FAULT_SUMMARY_STATUS <= STATUS_RESET;
            THERMAL_SWITCH_CURRENT_STATUS <= STATUS_RESET;
            SUPPLY_LINK_ERROR_STATUS <= STATUS_RESET;
        end else begin
            FAULT_SUMMARY_STATUS <= next_summary;
            THERMAL_SWITCH_CURRENT_STATUS <= next_thermal_switch;
            SUPPLY_LINK_ERROR_STATUS <= next_supply_link;
        end
    end

    // ------------------------------------------------------------
    // Reply word
    // ------------------------------------------------------------
    // Control offsets belong to another block; they read zero here
    logic [7:0] next_reply_data;

    always_comb begin
        unique case (word_addr)
            OFS_SUMMARY: next_reply_data = FAULT_SUMMARY_STATUS;
            OFS_THERMAL_SWITCH:
                next_reply_data = THERMAL_SWITCH_CURRENT_STATUS;
            OFS_SUPPLY_LINK: next_reply_data = SUPPLY_LINK_ERROR_STATUS;
            default: next_reply_data = STATUS_RESET;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            REPLY_VALID <= 1'b0;
            REPLY_STATUS <= STATUS_RESET;
            REPLY_DATA <= STATUS_RESET;
            REPLY_IN_RANGE <= 1'b0;
        end else begin
            REPLY_VALID <= WORD_VALID;
            if (WORD_VALID) begin
                REPLY_STATUS <= FAULT_SUMMARY_STATUS;
                REPLY_DATA <= next_reply_data;
                REPLY_IN_RANGE <= ~addr_bad;
            end
        end
    end

endmodule

`default_nettype wire

// *** verif/fsrb_properties.sv ***
/* Assertions on the status bank ports.
   Assumes one clock domain and a synchronous active-high reset. */
`default_nettype none
module fsrb_properties
    import fsrb_pkg::*;
(
    // Clock, reset and causes
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic STALL_DETECT,
    input wire logic [SWITCH_COUNT-1:0] SWITCH_OVERCURRENT,
    input wire logic WORD_VALID,
    input wire logic [WORD_W-1:0] SERIAL_WORD,
    input wire logic FRAME_SHORT,
    input wire logic CLEAR_FAULTS,
    // Effects
    input wire logic REPLY_VALID,
    input wire logic [7:0] FAULT_SUMMARY_STATUS,
    input wire logic [7:0] THERMAL_SWITCH_CURRENT_STATUS,
    input wire logic [7:0] SUPPLY_LINK_ERROR_STATUS
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic [7:0] s, t, e;
    assign s = FAULT_SUMMARY_STATUS;
    assign t = THERMAL_SWITCH_CURRENT_STATUS;
    assign e = SUPPLY_LINK_ERROR_STATUS;
    // Set wins over a clear in the same cycle
    sequence s_short; FRAME_SHORT; endsequence
    // A short frame right after the clear sets the flag again
    sequence s_clear;
        CLEAR_FAULTS && !FRAME_SHORT ##1 !FRAME_SHORT;
    endsequence
    a_stall_follow:
        assert property (!$past(RST) |-> s[7] == $past(STALL_DETECT))
        else $error("stall bit differs");
    a_switch_map:
        assert property (!$past(RST) |-> t[5:0] == $past(SWITCH_OVERCURRENT))
        else $error("switch bits differ");
    a_summary_group:
        assert property ({s[6], s[5], s[4], s[1]} ==
            {|e[5:4], |e[2:0], |t[5:0], |t[7:6]}) else $error("group bits");
    a_global_fault:
        assert property (s[0] == (s[7] | s[2] | (|t) | (|e)))
        else $error("global bit differs");
    a_reserved_zero:
        assert property (e[7] == 1'b0) else $error("reserved bit set");
    a_reply_pulse:
        assert property (!$past(RST) |-> REPLY_VALID == $past(WORD_VALID))
        else $error("reply strobe timing");
    a_short_latch:
        assert property (s_short |-> ##2 e[1]) else $error("framing not set");
    a_clear_drop:
        assert property (s_clear |-> ##1 !e[1]) else $error("framing kept");
    a_parity_latch:
        assert property (WORD_VALID && ^SERIAL_WORD |-> ##2 e[2])
        else $error("parity not set");
    a_addr_latch:
        assert property (WORD_VALID && SERIAL_WORD[14:9] > 6'h0C |-> ##2 e[0])
        else $error("address not set");
endmodule
bind fsrb_top fsrb_properties u_props (.SYS_CLK(SYS_CLK), .RST(RST),
    .STALL_DETECT(STALL_DETECT), .SWITCH_OVERCURRENT(SWITCH_OVERCURRENT),
    .WORD_VALID(WORD_VALID), .SERIAL_WORD(SERIAL_WORD),
    .FRAME_SHORT(FRAME_SHORT), .CLEAR_FAULTS(CLEAR_FAULTS),
    .REPLY_VALID(REPLY_VALID), .FAULT_SUMMARY_STATUS(FAULT_SUMMARY_STATUS),
    .THERMAL_SWITCH_CURRENT_STATUS(THERMAL_SWITCH_CURRENT_STATUS),
    .SUPPLY_LINK_ERROR_STATUS(SUPPLY_LINK_ERROR_STATUS));
`default_nettype wire

// *** verif/fsrb_controller.sv ***
/* Model of the serial controller handing over whole words.
   Assumes requests from the bench change just after a rising edge. */
`default_nettype none
module fsrb_controller
    import fsrb_pkg::*;
(
    input wire logic clk,
    input wire logic send,
    input wire logic [WORD_W-1:0] word,
    input wire logic bad_parity,
    output logic word_valid,
    output logic [WORD_W-1:0] serial_word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial serial_word = 16'h0000;
    always @(posedge clk) begin
        word_valid <= send;
        if (send) begin
            // Even count of ones unless told otherwise
            serial_word <= {word[15:9], ^{word[15:9], word[7:0]} ^ bad_parity,
                word[7:0]};
        end else begin
            // Idle word toggles so no stale value passes as real
            serial_word <= ~serial_word;
        end
    end
endmodule
`default_nettype wire

// *** verif/fsrb_top_tb.sv ***
/* Self-checking bench for the status bank.
   Assumes a 200 MHz clock and the controller model beside it. */
`default_nettype none
module fsrb_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fsrb_pkg::*;
    logic clk, rst = 1, send = 0, bad = 0, fshort = 0, clr = 0, slp = 0;
    logic [14:0] det = 15'h0000;
    logic [2:0] err = 3'h0;
    logic [15:0] word = 16'h0000, sw;
    logic wv, rv, rin;
    logic [7:0] rs, rd, r0, r1, r2;
    int mismatches = 0, samples_checked = 0;
    fsrb_controller ctl (.clk(clk), .send(send), .word(word),
        .bad_parity(bad), .word_valid(wv), .serial_word(sw));
    fsrb_top dut (.SYS_CLK(clk), .RST(rst), .STALL_DETECT(det[14]),
        .SUPPLY_OVERVOLT(det[13]), .SUPPLY_RESET_SEEN(det[12]),
        .THERMAL_WARNING(det[11]), .THERMAL_SHUTDOWN(det[10]),
        .SWITCH_OVERCURRENT(det[9:4]), .MEMORY_ERROR(det[3]),
        .STEPDOWN_OVERCURRENT(det[2]), .STEPDOWN_UNDERVOLT(det[1]),
        .CHARGE_PUMP_UNDERVOLT(det[0]), .WORD_VALID(wv), .SERIAL_WORD(sw),
        .FRAME_SHORT(fshort), .CLEAR_FAULTS(clr), .SLEEP_RESET_PULSE(slp),
        .REPLY_VALID(rv), .REPLY_STATUS(rs), .REPLY_DATA(rd),
        .REPLY_IN_RANGE(rin), .FAULT_SUMMARY_STATUS(r0),
        .THERMAL_SWITCH_CURRENT_STATUS(r1), .SUPPLY_LINK_ERROR_STATUS(r2));
    // ----------------------------------------
    // Expectations and helpers
    // ----------------------------------------
    function automatic logic [23:0] expv();
        logic [7:0] t, e, s;
        t = det[11:4];
        e = {1'b0, det[3:0], err};
        s = {det[14], |e[5:4], |err, |t[5:0], !det[12], det[13], |t[7:6], 1'b0};
        s[0] = det[14] | det[13] | (|t) | (|e);
        return {s, t, e};
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pulse(input logic f, input logic c, input logic p);
        @(posedge clk);
        {fshort, clr, slp} <= {f, c, p};
        @(posedge clk);
        {fshort, clr, slp} <= 3'h0;
        settle();
    endtask
    task automatic xfer(input logic [5:0] a, input logic w, input logic b);
        logic [23:0] x;
        logic [7:0] d;
        x = expv();
        d = a == 6'h00 ? x[23:16] : a == 6'h01 ? x[15:8] :
            a == 6'h02 ? x[7:0] : 8'h00;
        @(posedge clk);
        {word, bad, send} <= {w, a, 9'h1A5, b, 1'b1};
        @(posedge clk);
        {bad, send} <= 2'h0;
        for (int n = 0; n < 4 && rv !== 1'b1; n++) @(negedge clk);
        chk({rs, rd, 6'h00, rv, rin}, {x[23:16], d, 7'h01, a <= 6'h0C});
        err = err | {b, 1'b0, a > 6'h0C};
        settle();
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_levels();
        logic [23:0] x;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            det <= i < 15 ? 15'h0001 << i : 15'h7FFF;
            settle();
            x = expv();
            chk({r0, 16'h0000}, {x[23:16], 16'h0000});
            chk({8'h00, r1, r2}, {8'h00, x[15:0]});
        end
    endtask
    task automatic t_access();
        logic [5:0] adr [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0C, 6'h0D};
        @(posedge clk);
        det <= 15'h2A5A;
        // Let the new levels reach the registers before expecting them
        settle();
        foreach (adr[k]) xfer(adr[k], 1'b1, 1'b0);
        xfer(6'h01, 1'b0, 1'b0);
        xfer(6'h3F, 1'b0, 1'b1);
        chk({r0, r1, r2}, expv());
    endtask
    task automatic t_errors();
        pulse(1'b1, 1'b0, 1'b0);
        err[1] = 1'b1;
        chk({r0, r1, r2}, expv());
        pulse(1'b0, 1'b1, 1'b0);
        err = 3'h0;
        chk({r0, r1, r2}, expv());
        pulse(1'b1, 1'b1, 1'b0);
        err[1] = 1'b1;
        chk({r0, r1, r2}, expv());
        pulse(1'b0, 1'b0, 1'b1);
        err = 3'h0;
        chk({r0, r1, r2}, expv());
    endtask
    task automatic t_reset();
        pulse(1'b1, 1'b0, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk({r0, r1, r2}, 24'h00_0000);
        @(posedge clk);
        rst <= 1'b0;
        err = 3'h0;
        settle();
        chk({r0, r1, r2}, expv());
    endtask
    task automatic summarize();
        if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        // Whole run is under two hundred cycles
        repeat (5000) @(posedge clk);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (15) @(posedge clk);
        @(negedge clk);
        chk({r0, r1, r2}, 24'h00_0000);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        // Summary bit 3 shows no supply reset once detectors are seen
        chk({r0, r1, r2}, expv());
        t_levels();
        t_access();
        t_errors();
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
